// ===== core/dcet_pkg.sv
// Purpose: Constants for the DMA channel event trigger block
// Assumes: AXI4-Lite, 32-bit data, word aligned registers
// Notes: Offsets are byte addresses
package dcet_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EVENT_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CHAN_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  // ----------------------------------------------------------------
  // Event control fields
  // ----------------------------------------------------------------
  localparam int ABORT_SEL_LSB = 16;
  localparam int START_SEL_LSB = 8;
  localparam int FORCE_BIT = 7;
  localparam int ABORT_BIT = 6;
  localparam int PATTERN_EN_BIT = 5;
  localparam int START_EN_BIT = 4;
  localparam int ABORT_EN_BIT = 3;
  localparam logic [7:0] SEL_RESET = 8'hFF;
  // ----------------------------------------------------------------
  // Channel control and status fields
  // ----------------------------------------------------------------
  localparam int CHAN_EN_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int STAT_ABORT_BIT = 0;
  localparam int STAT_START_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_WIDTH = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_IRQ = 256;
  // Channel engine states
  typedef enum logic [0:0] {CH_IDLE, CH_BUSY} dcet_chan_type;
endpackage : dcet_pkg

// ===== core/dcet_trig_if.sv
// Purpose: Trigger hand-off between register side and match logic
// Assumes: Single clock
// Notes: Carries request lines, selectors and decoded hits
`timescale 1ns/1ns
`default_nettype none
interface dcet_trig_if;
  logic [255:0] irq_lines;
  logic [7:0] start_sel;
  logic [7:0] abort_sel;
  logic start_hit;
  logic abort_hit;
  modport ctrl (output irq_lines, output start_sel, output abort_sel,
    input start_hit, input abort_hit);
  modport match (input irq_lines, input start_sel, input abort_sel,
    output start_hit, output abort_hit);
endinterface : dcet_trig_if
`default_nettype wire

// ===== core/dcet_irq_match.sv
// Purpose: Pick the selected request line for start and abort
// Assumes: Request lines are synchronous pulses or levels
// Notes: Purely combinational selection
`timescale 1ns/1ns
`default_nettype none
module dcet_irq_match (
  // Trigger link
  dcet_trig_if.match trig
);
  // ------------------------------------------------------------
  // Selection
  // ------------------------------------------------------------
  // Index request vector by selector number
  assign trig.start_hit = trig.irq_lines[trig.start_sel];
  assign trig.abort_hit = trig.irq_lines[trig.abort_sel];
endmodule : dcet_irq_match
`default_nettype wire

// ===== core/dcet_channel.sv
// Purpose: DMA channel start and abort event control with AXI4-Lite slave
// Assumes: IRQ and pattern inputs synchronous to SYS_CLK
// Notes: Start and abort go to the transfer engine as one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
// Function
// - Abort selector, bits 23:16, read/write, resets to all ones.
// - Start selector, bits 15:8, read/write, resets to all ones.
// - Selected abort interrupt aborts transfer and sets abort flag when enabled.
// - Start selector names interrupt that begins a transfer when enabled.
// - Writing force bit starts transfer at once when channel enabled; reads zero.
// - Writing abort bit aborts transfer; reads zero.
// - Pattern abort enabled: match aborts and clears channel enable.
// - Start enable clear: selected interrupt ignored for starting.
// - Abort enable clear: selected interrupt ignored for aborting.
// - Bits 31:24 and 2:0 read zero; enables reset to zero.
module dcet_channel (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // AXI4-Lite write address
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Event sources
  input wire logic [255:0] IRQ_LINES,
  input wire logic PATTERN_MATCH,
  input wire logic XFER_DONE,
  // Transfer engine
  output logic XFER_START,
  output logic XFER_ABORT,
  output logic CHAN_BUSY,
  // Interrupt
  output logic IRQ
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0] abort_sel_r;
  logic [7:0] start_sel_r;
  logic pattern_en_r;
  logic start_en_r;
  logic abort_en_r;
  logic chan_en_r;
  logic [2:0] stat_r;
  logic [2:0] stat_nxt;
  logic [2:0] mask_r;
  dcet_pkg::dcet_chan_type state_r;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic do_read;
  logic wr_ec;
  logic wr_cc;
  logic wr_mask;
  logic force_req;
  logic abort_req;
  logic start_evt;
  logic abort_evt;
  logic pattern_evt;
  logic [31:0] rd_value;
  logic rd_ok;
  logic [31:0] ec_value;
  dcet_trig_if trig ();

  // ------------------------------------------------------------
  // Request matching
  // ------------------------------------------------------------
  assign trig.irq_lines = IRQ_LINES;
  assign trig.start_sel = start_sel_r;
  assign trig.abort_sel = abort_sel_r;
  dcet_irq_match u_match (
    .trig(trig.match)
  );

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  // Hold address and data until both have arrived
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Ready while the channel slot is empty and no response pends
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_held_r && !(S_AXI_AWVALID && S_AXI_AWREADY)
        && !S_AXI_BVALID && !do_write;
      S_AXI_WREADY <= !w_held_r && !(S_AXI_WVALID && S_AXI_WREADY)
        && !S_AXI_BVALID && !do_write;
    end
  end

  assign do_write = aw_held_r && w_held_r && !S_AXI_BVALID;
  assign wr_ec = do_write && (awaddr_r == dcet_pkg::ADDR_EVENT_CONTROL);
  assign wr_cc = do_write && (awaddr_r == dcet_pkg::ADDR_CHAN_CONTROL);
  assign wr_mask = do_write && (awaddr_r == dcet_pkg::ADDR_IRQ_MASK);

  // Write response, error on unmapped address
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= dcet_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (wr_ec || wr_cc || wr_mask
        || awaddr_r == dcet_pkg::ADDR_IRQ_STATUS) ?
        dcet_pkg::RESP_OKAY : dcet_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Event control register
  // ------------------------------------------------------------
  // Selectors and enables, per byte lane
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      abort_sel_r <= dcet_pkg::SEL_RESET;
      start_sel_r <= dcet_pkg::SEL_RESET;
      pattern_en_r <= 1'b0;
      start_en_r <= 1'b0;
      abort_en_r <= 1'b0;
    end else if (wr_ec) begin
      if (wstrb_r[2]) begin
        abort_sel_r <= wdata_r[dcet_pkg::ABORT_SEL_LSB +: 8];
      end
      if (wstrb_r[1]) begin
        start_sel_r <= wdata_r[dcet_pkg::START_SEL_LSB +: 8];
      end
      if (wstrb_r[0]) begin
        pattern_en_r <= wdata_r[dcet_pkg::PATTERN_EN_BIT];
        start_en_r <= wdata_r[dcet_pkg::START_EN_BIT];
        abort_en_r <= wdata_r[dcet_pkg::ABORT_EN_BIT];
      end
    end
  end

  // Force and abort are write-one actions, never stored
  assign force_req = wr_ec && wstrb_r[0] && wdata_r[dcet_pkg::FORCE_BIT];
  assign abort_req = wr_ec && wstrb_r[0] && wdata_r[dcet_pkg::ABORT_BIT];

  // ------------------------------------------------------------
  // Trigger decisions
  // ------------------------------------------------------------
  assign pattern_evt = pattern_en_r && PATTERN_MATCH;
  assign abort_evt = (abort_en_r && trig.abort_hit) || abort_req || pattern_evt;
  assign start_evt = ((start_en_r && trig.start_hit) || force_req) && chan_en_r;

  // Channel enable, cleared by pattern abort
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      chan_en_r <= 1'b0;
    end else if (pattern_evt) begin
      chan_en_r <= 1'b0;
    end else if (wr_cc && wstrb_r[0]) begin
      chan_en_r <= wdata_r[dcet_pkg::CHAN_EN_BIT];
    end
  end

  // Channel engine state and command pulses
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= dcet_pkg::CH_IDLE;
      XFER_START <= 1'b0;
      XFER_ABORT <= 1'b0;
      CHAN_BUSY <= 1'b0;
    end else begin
      XFER_START <= 1'b0;
      XFER_ABORT <= 1'b0;
      unique case (state_r)
        dcet_pkg::CH_IDLE: begin
          if (abort_evt) begin
            XFER_ABORT <= 1'b1;
          end else if (start_evt) begin
            XFER_START <= 1'b1;
            state_r <= dcet_pkg::CH_BUSY;
            CHAN_BUSY <= 1'b1;
          end
        end
        dcet_pkg::CH_BUSY: begin
          if (abort_evt) begin
            XFER_ABORT <= 1'b1;
            state_r <= dcet_pkg::CH_IDLE;
            CHAN_BUSY <= 1'b0;
          end else if (XFER_DONE) begin
            state_r <= dcet_pkg::CH_IDLE;
            CHAN_BUSY <= 1'b0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  // Sticky events; a status read clears, a new event wins
  always_comb begin
    stat_nxt = stat_r;
    if (do_read && S_AXI_ARADDR == dcet_pkg::ADDR_IRQ_STATUS) begin
      stat_nxt = 3'h0;
    end
    if (abort_evt && (state_r == dcet_pkg::CH_BUSY || abort_en_r)) begin
      stat_nxt[dcet_pkg::STAT_ABORT_BIT] = 1'b1;
    end
    if (start_evt && !abort_evt) begin
      stat_nxt[dcet_pkg::STAT_START_BIT] = 1'b1;
    end
    if (state_r == dcet_pkg::CH_BUSY && XFER_DONE && !abort_evt) begin
      stat_nxt[dcet_pkg::STAT_DONE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      stat_r <= 3'h0;
      mask_r <= 3'h0;
      IRQ <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_mask && wstrb_r[0]) begin
        mask_r <= wdata_r[dcet_pkg::STAT_WIDTH-1:0];
      end
      IRQ <= |(stat_nxt & mask_r);
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  assign do_read = S_AXI_ARVALID && S_AXI_ARREADY;
  assign ec_value = {8'h00, abort_sel_r, start_sel_r, 2'b00, pattern_en_r,
    start_en_r, abort_en_r, 3'b000};

  // Read value mux
  always_comb begin
    rd_ok = 1'b1;
    rd_value = 32'h0000_0000;
    unique case (S_AXI_ARADDR)
      dcet_pkg::ADDR_EVENT_CONTROL: rd_value = ec_value;
      dcet_pkg::ADDR_CHAN_CONTROL: rd_value = {30'h0, CHAN_BUSY, chan_en_r};
      dcet_pkg::ADDR_IRQ_STATUS: rd_value = {29'h0, stat_r};
      dcet_pkg::ADDR_IRQ_MASK: rd_value = {29'h0, mask_r};
      default: rd_ok = 1'b0;
    endcase
  end

  // Accept one read, answer next cycle
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= dcet_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !do_read;
      if (do_read) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_value;
        S_AXI_RRESP <= rd_ok ? dcet_pkg::RESP_OKAY : dcet_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule : dcet_channel
`default_nettype wire

// ===== test/dcet_engine_model.sv
// Purpose: Transfer engine stand-in for the event trigger block
// Assumes: Start and abort arrive as one-cycle pulses
// Notes: Done follows start after lat cycles; lat of zero stalls until abort
`timescale 1ns/1ns
`default_nettype none
module dcet_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Channel side
  input wire logic start,
  input wire logic abort,
  input wire logic [7:0] lat,
  output logic done
);
  // ----------------------------------------------------------------
  // Transfer countdown
  // ----------------------------------------------------------------
  int cnt_r;
  // Count a running transfer down, cancel it on abort
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 0;
      done <= 1'b0;
    end else begin
      done <= (cnt_r == 1) && !abort;
      if (start) cnt_r <= int'(lat);
      else if (abort) cnt_r <= 0;
      else if (cnt_r > 0) cnt_r <= cnt_r - 1;
    end
  end
endmodule : dcet_engine_model
`default_nettype wire

// ===== test/dcet_props.sv
// Purpose: Port-level checks for the DMA channel event trigger
// Assumes: Single clock, active-low asynchronous reset
// Notes: Bound to every instance of the channel block
`timescale 1ns/1ns
`default_nettype none
module dcet_props (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // Register bus
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Engine side
  input wire logic XFER_DONE,
  input wire logic XFER_START,
  input wire logic XFER_ABORT,
  input wire logic CHAN_BUSY
);
  // ----------------------------------------------------------------
  // Transfer control and bus answers
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  // A transfer ends by abort or by the engine's done
  sequence s_stop;
    XFER_ABORT || $past(XFER_DONE);
  endsequence
  property p_abort_wins;
    !(XFER_START && XFER_ABORT);
  endproperty
  a_abort_wins: assert property (p_abort_wins) else $error("start with abort");
  property p_abort_idle;
    XFER_ABORT |-> !CHAN_BUSY;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("busy after abort");
  property p_busy_start;
    $rose(CHAN_BUSY) |-> XFER_START;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy without start");
  property p_busy_end;
    $fell(CHAN_BUSY) |-> s_stop;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy dropped alone");
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_zero;
    S_AXI_RVALID |-> S_AXI_RDATA[31:24] == 8'h00 && S_AXI_RDATA[7:6] == 2'h0;
  endproperty
  a_r_zero: assert property (p_r_zero) else $error("unused bits read set");
  property p_ar_refuse;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken early");
  property p_w_refuse;
    S_AXI_BVALID |-> !(S_AXI_AWREADY || S_AXI_WREADY);
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken early");
endmodule : dcet_props
bind dcet_channel dcet_props i_props (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .XFER_DONE(XFER_DONE), .XFER_START(XFER_START), .XFER_ABORT(XFER_ABORT),
  .CHAN_BUSY(CHAN_BUSY));
`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench for the DMA channel event trigger
// Assumes: Engine model closes transfers; bench drives request lines
// Notes: Pulse counts from a monitor are compared with a bench model
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [7:0] A_EC = dcet_pkg::ADDR_EVENT_CONTROL;
  localparam logic [7:0] A_CH = dcet_pkg::ADDR_CHAN_CONTROL;
  localparam logic [7:0] A_ST = dcet_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] A_MK = dcet_pkg::ADDR_IRQ_MASK;
  localparam logic [1:0] OK = dcet_pkg::RESP_OKAY;
  logic clk = 1'b0, rst_b = 1'b0, pat = 1'b0, aw_valid = 1'b0, w_valid = 1'b0;
  logic b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00, lat = 8'h00, s;
  logic [31:0] w_data = 32'h0, seed = 32'hEF0C2034, r_data, v;
  logic [3:0] w_strb = 4'hF;
  logic [255:0] irq_lines = '0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, x_start, x_abort, busy, irq, done;
  logic [1:0] b_resp, r_resp;
  int failures = 0, tests_run = 0, st_cnt = 0, ab_cnt = 0, exp_st = 0, exp_ab = 0, i;
  dcet_channel i_dut (.SYS_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(aw_addr),
    .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data),
    .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
    .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
    .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
    .S_AXI_RREADY(r_ready), .IRQ_LINES(irq_lines), .PATTERN_MATCH(pat), .XFER_DONE(done),
    .XFER_START(x_start), .XFER_ABORT(x_abort), .CHAN_BUSY(busy), .IRQ(irq));
  dcet_engine_model i_eng (.clk(clk), .rst_b(rst_b), .start(x_start), .abort(x_abort),
    .lat(lat), .done(done));
  // Free-running clock
  initial begin
    forever #20 clk = ~clk;
  end
  // Count start and abort pulses
  always @(posedge clk) begin
    st_cnt += int'(x_start);
    ab_cnt += int'(x_abort);
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid) break;
    end
    chk("bresp", {30'h0, b_resp}, {30'h0, er});
    b_ready <= 1'b0;
    if (n == 40) begin
      failures++;
      finish_test();
    end
    @(posedge clk);
  endtask : wr
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    int n;
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_valid) break;
    end
    chk(nm, r_data, e);
    chk("rresp", {30'h0, r_resp}, {30'h0, (a > A_MK) ? dcet_pkg::RESP_SLVERR : OK});
    r_ready <= 1'b0;
    if (n == 40) begin
      failures++;
      finish_test();
    end
    @(posedge clk);
  endtask : rc
  // One-cycle request line, or pattern match for n above 255
  task automatic fire(input int n);
    if (n > 255) pat <= 1'b1;
    else irq_lines[n] <= 1'b1;
    @(posedge clk);
    pat <= 1'b0;
    irq_lines <= '0;
    repeat (3) @(posedge clk);
  endtask : fire
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rc("ec_rst", A_EC, 32'h00FFFF00);
    rc("ch_rst", A_CH, 32'h0);
    rc("mask_rst", A_MK, 32'h0);
    for (i = 0; i < 6; i++) begin
      v = rnd();
      wr(A_EC, v, OK);
      exp_ab += int'(v[6]);
      rc("ec_rw", A_EC, v & 32'h00FFFF38);
    end
    chk("abort_wr", ab_cnt, exp_ab);
    // Start selector lane alone, other fields keep their values
    w_strb <= 4'h2;
    wr(A_EC, 32'hFFFFFFFF, OK);
    w_strb <= 4'hF;
    rc("ec_lane", A_EC, (v & 32'h00FF0038) | 32'h0000FF00);
    wr(8'h10, 32'hFFFFFFFF, dcet_pkg::RESP_SLVERR);
    rc("unmapped", 8'h10, 32'h0);
    wr(A_CH, 32'h1, OK);
    for (i = 0; i < 4; i++) begin
      v = rnd();
      s = v[7:0];
      wr(A_EC, {8'h00, s ^ 8'h5A, s, 3'h0, i[0], i[1], 3'h0}, OK);
      fire(int'(s));
      exp_st += int'(i[0]);
      chk("irq_start", st_cnt, exp_st);
      fire(int'(s ^ 8'h5A));
      exp_ab += int'(i[1]);
      chk("irq_abort", ab_cnt, exp_ab);
      chk("busy", {31'h0, busy}, {31'h0, i[0] & ~i[1]});
      wr(A_EC, 32'h40, OK);
      exp_ab++;
    end
    lat <= 8'h03;
    wr(A_EC, 32'h80, OK);
    exp_st++;
    repeat (6) @(posedge clk);
    chk("force_start", st_cnt, exp_st);
    chk("force_done", {31'h0, busy}, 32'h0);
    lat <= 8'h00;
    wr(A_EC, 32'h80, OK);
    exp_st++;
    fire(256);
    chk("pat_off", ab_cnt, exp_ab);
    wr(A_EC, 32'h20, OK);
    fire(256);
    exp_ab++;
    chk("pat_on", ab_cnt, exp_ab);
    rc("chan_off", A_CH, 32'h0);
    wr(A_CH, 32'h1, OK);
    wr(A_EC, 32'h00777718, OK);
    fire(119);
    exp_ab++;
    chk("both_start", st_cnt, exp_st);
    chk("both_abort", ab_cnt, exp_ab);
    chk("both_idle", {31'h0, busy}, 32'h0);
    rc("status_any", A_ST, 32'h7);
    wr(A_MK, 32'h1, OK);
    wr(A_EC, 32'h80, OK);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(A_EC, 32'h40, OK);
    chk("irq_set", {31'h0, irq}, 32'h1);
    rc("status", A_ST, 32'h3);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    finish_test();
  end
endmodule : tb
`default_nettype wire
